// ==== timer16_pkg.sv ====
// Constants, register map and carrier types of the 16-bit waveform timer
package timer16_pkg;
	localparam int AXI_ADDR_W = 8;
	// Register byte offsets
	localparam logic [7:0] OFF_CTRL = 8'h00;
	localparam logic [7:0] OFF_FORCE = 8'h04;
	localparam logic [7:0] OFF_COUNT = 8'h08;
	localparam logic [7:0] OFF_CMPA = 8'h0C;
	localparam logic [7:0] OFF_CMPB = 8'h10;
	localparam logic [7:0] OFF_CAPTOP = 8'h14;
	localparam logic [7:0] OFF_FLAGS = 8'h18;
	localparam logic [7:0] OFF_STATUS = 8'h1C;
	// Waveform mode field encodings handled here
	localparam logic [3:0] MODE_NORMAL = 4'h0;
	localparam logic [3:0] MODE_CLR_A = 4'h4;
	localparam logic [3:0] MODE_FAST8 = 4'h5;
	localparam logic [3:0] MODE_FAST9 = 4'h6;
	localparam logic [3:0] MODE_FAST10 = 4'h7;
	localparam logic [3:0] MODE_CLR_CAP = 4'hC;
	localparam logic [3:0] MODE_FAST_CAP = 4'hE;
	localparam logic [3:0] MODE_FAST_A = 4'hF;
	// Compare output action field encodings
	localparam logic [1:0] ACT_NONE = 2'h0;
	localparam logic [1:0] ACT_TOGGLE = 2'h1;
	localparam logic [1:0] ACT_LOW_MATCH = 2'h2;
	localparam logic [1:0] ACT_HIGH_MATCH = 2'h3;
	// Counter values
	localparam logic [15:0] TOP_FIXED8 = 16'h00FF;
	localparam logic [15:0] TOP_FIXED9 = 16'h01FF;
	localparam logic [15:0] TOP_FIXED10 = 16'h03FF;
	localparam logic [15:0] COUNT_MAX = 16'hFFFF;
	localparam logic [15:0] COUNT_BOTTOM = 16'h0000;
	localparam logic [15:0] COUNT_ONE = 16'h0001;
	// Bit positions in the flag and force registers
	localparam int FLAG_OVF = 0;
	localparam int FLAG_MATCH_A = 1;
	localparam int FLAG_MATCH_B = 2;
	localparam int FLAG_CAPTURE = 3;
	localparam int FORCE_A = 0;
	localparam int FORCE_B = 1;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef struct packed {
		logic dir_b;
		logic dir_a;
		logic [1:0] act_b;
		logic [1:0] act_a;
		logic [3:0] mode;
	} ctrl_t;

	typedef struct packed {
		logic awvalid;
		logic [AXI_ADDR_W-1:0] awaddr;
		logic wvalid;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic bready;
		logic arvalid;
		logic [AXI_ADDR_W-1:0] araddr;
		logic rready;
	} axi_req_t;

	typedef struct packed {
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} axi_rsp_t;

	typedef struct packed {
		logic [15:0] count;
		logic [15:0] cmpa_buf;
		logic [15:0] cmpa_act;
		logic [15:0] cmpb_buf;
		logic [15:0] cmpb_act;
		logic [15:0] captop;
		ctrl_t ctrl;
		logic [3:0] flags;
		logic out_a;
		logic out_b;
		logic block;
		logic aw_held;
		logic w_held;
		logic [AXI_ADDR_W-1:0] awaddr;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} state_t;

	localparam state_t STATE_RST = '0;
endpackage

// ==== timer16_waveform_modes.sv ====
// Counting modes, compare outputs and register slave of the 16-bit waveform timer
`timescale 1ns/1ps
// How it works
// - Action zero leaves output state untouched
// - New action field used at next match
// - Force strobe applies action at once, non-PWM
// - Counting depends on waveform mode only
// - Mode zero counts up, wraps, writable
// - Normal overflow flag set as count becomes zero
// - Clear-on-match clears at compare A or capture
// - Clear-on-match TOP unbuffered; missed TOP wraps
// - Clear-on-match TOP sets its register's flag
// - Clear-on-match action one toggles output A
// - Clear-on-match overflow only at max rollover
// - Fast PWM fixed or register TOP, then clear
// - Fast PWM set/clear at match and bottom
// - Fast PWM actions two, three opposite polarity
// - Fast PWM overflow and TOP flag at TOP
// - Fixed TOP masks compare writes
// - Compare above TOP never matches
// - Capture TOP unbuffered in fast PWM
// - PWM compare buffered, loaded at TOP
// - Compare zero spikes, compare TOP is constant
// - Fast PWM toggle only with compare A TOP
// - Pin shows state only when direction output
// - Output states reset to zero

module timer16_waveform_modes
	import timer16_pkg::*;
(
	input wire logic clk, // System clock
	input wire logic rst, // Synchronous reset
	input wire logic timer_tick, // One pulse per timer clock
	input wire axi_req_t axi_req, // AXI4-Lite requests
	output axi_rsp_t axi_rsp, // AXI4-Lite answers
	output logic pin_a_out, // Channel A pin level
	output logic pin_a_en, // Channel A pin driven
	output logic pin_b_out, // Channel B pin level
	output logic pin_b_en // Channel B pin driven
);

	state_t s;
	state_t n;

	logic [3:0] mode;
	logic is_pwm;
	logic is_clr;
	logic is_norm;
	logic is_fixed;
	logic active;
	logic cap_top;
	logic [15:0] top;
	logic [15:0] eff_a;
	logic [15:0] eff_b;
	logic [15:0] cmp_mask;
	logic run;
	logic at_top;
	logic hit_a;
	logic hit_b;
	logic cap_hit;
	logic clear_cnt;
	logic wrap;
	logic ovf_set;
	logic aw_fire;
	logic w_fire;
	logic do_wr;
	logic [7:0] waddr;
	logic [7:0] raddr;
	logic [31:0] wd;
	logic [3:0] ws;
	logic wr_ctrl;
	logic wr_force;
	logic wr_count;
	logic wr_cmpa;
	logic wr_cmpb;
	logic wr_captop;
	logic wr_flags;
	logic wr_known;
	logic [3:0] flag_clr;
	logic force_a;
	logic force_b;
	logic [15:0] ctrl_merged;

	function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
		input logic [3:0] st);
		merge16 = {st[1] ? d[15:8] : old[15:8], st[0] ? d[7:0] : old[7:0]};
	endfunction

	// Next output state of one channel
	function automatic logic wave_next(input logic cur, input logic [1:0] act, input logic pwm,
		input logic toggle_ok, input logic match, input logic bottom);
		wave_next = cur;
		if (!pwm)
		begin
			if (match)
			begin
				case (act)
					ACT_TOGGLE: wave_next = ~cur;
					ACT_LOW_MATCH: wave_next = 1'b0;
					ACT_HIGH_MATCH: wave_next = 1'b1;
					default: wave_next = cur;
				endcase
			end
		end
		else
		begin
			// Bottom wins over a match at TOP, so compare equal to TOP holds one level
			case (act)
				ACT_TOGGLE: wave_next = (match && toggle_ok) ? ~cur : cur;
				ACT_LOW_MATCH: wave_next = bottom ? 1'b1 : (match ? 1'b0 : cur);
				ACT_HIGH_MATCH: wave_next = bottom ? 1'b0 : (match ? 1'b1 : cur);
				default: wave_next = cur;
			endcase
		end
	endfunction

	// ----------------------------------------
	// Mode decode
	// ----------------------------------------
	assign mode = s.ctrl.mode;
	assign is_norm = (mode == MODE_NORMAL);
	assign is_clr = (mode == MODE_CLR_A) || (mode == MODE_CLR_CAP);
	assign is_fixed = (mode == MODE_FAST8) || (mode == MODE_FAST9) || (mode == MODE_FAST10);
	assign is_pwm = is_fixed || (mode == MODE_FAST_CAP) || (mode == MODE_FAST_A);
	assign cap_top = (mode == MODE_CLR_CAP) || (mode == MODE_FAST_CAP);
	assign active = is_norm || is_clr || is_pwm;

	// Non-PWM compares use the written value directly
	assign eff_a = is_pwm ? s.cmpa_act : s.cmpa_buf;
	assign eff_b = is_pwm ? s.cmpb_act : s.cmpb_buf;

	always_comb
	begin
		case (mode)
			MODE_CLR_A: top = eff_a;
			MODE_FAST8: top = TOP_FIXED8;
			MODE_FAST9: top = TOP_FIXED9;
			MODE_FAST10: top = TOP_FIXED10;
			MODE_CLR_CAP: top = s.captop;
			MODE_FAST_CAP: top = s.captop;
			MODE_FAST_A: top = s.cmpa_act;
			default: top = COUNT_MAX;
		endcase
	end

	assign cmp_mask = is_fixed ? top : COUNT_MAX;

	// ----------------------------------------
	// Counter events
	// ----------------------------------------
	// A count written by software blocks matches for one timer cycle
	assign run = timer_tick && active;
	assign at_top = (s.count == top) && !s.block;
	assign hit_a = run && !s.block && (s.count == eff_a);
	assign hit_b = run && !s.block && (s.count == eff_b);
	assign cap_hit = run && cap_top && at_top;
	assign clear_cnt = run && (is_clr || is_pwm) && at_top;
	assign wrap = run && (s.count == COUNT_MAX);
	assign ovf_set = is_pwm ? clear_cnt : wrap;

	// ----------------------------------------
	// Register bus decode
	// ----------------------------------------
	assign aw_fire = axi_req.awvalid && axi_rsp.awready;
	assign w_fire = axi_req.wvalid && axi_rsp.wready;
	assign do_wr = (s.aw_held || aw_fire) && (s.w_held || w_fire) && !s.bvalid;
	assign waddr = s.aw_held ? s.awaddr : axi_req.awaddr;
	assign raddr = {axi_req.araddr[7:2], 2'b00};
	assign wd = s.w_held ? s.wdata : axi_req.wdata;
	assign ws = s.w_held ? s.wstrb : axi_req.wstrb;

	always_comb
	begin
		wr_ctrl = 1'b0;
		wr_force = 1'b0;
		wr_count = 1'b0;
		wr_cmpa = 1'b0;
		wr_cmpb = 1'b0;
		wr_captop = 1'b0;
		wr_flags = 1'b0;
		wr_known = 1'b1;
		if ({waddr[7:2], 2'b00} == OFF_CTRL)
			wr_ctrl = do_wr;
		else if ({waddr[7:2], 2'b00} == OFF_FORCE)
			wr_force = do_wr;
		else if ({waddr[7:2], 2'b00} == OFF_COUNT)
			wr_count = do_wr;
		else if ({waddr[7:2], 2'b00} == OFF_CMPA)
			wr_cmpa = do_wr;
		else if ({waddr[7:2], 2'b00} == OFF_CMPB)
			wr_cmpb = do_wr;
		else if ({waddr[7:2], 2'b00} == OFF_CAPTOP)
			wr_captop = do_wr;
		else if ({waddr[7:2], 2'b00} == OFF_FLAGS)
			wr_flags = do_wr;
		else if ({waddr[7:2], 2'b00} != OFF_STATUS)
			wr_known = 1'b0;
	end

	assign flag_clr = (wr_flags && ws[0]) ? wd[3:0] : 4'h0;
	assign force_a = wr_force && ws[0] && wd[FORCE_A] && !is_pwm;
	assign force_b = wr_force && ws[0] && wd[FORCE_B] && !is_pwm;
	assign ctrl_merged = merge16({6'h00, s.ctrl}, wd, ws);

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb
	begin
		n = s;
		if (run)
		begin
			n.block = 1'b0;
			if (clear_cnt)
				n.count = COUNT_BOTTOM;
			else
				n.count = 16'(s.count + COUNT_ONE);
		end
		// Double buffered compares load at TOP, with the counter clear
		if (is_pwm && clear_cnt)
		begin
			n.cmpa_act = s.cmpa_buf;
			n.cmpb_act = s.cmpb_buf;
		end
		else if (!is_pwm)
		begin
			n.cmpa_act = s.cmpa_buf;
			n.cmpb_act = s.cmpb_buf;
		end
		// Hardware set wins over a software clear in the same cycle
		n.flags = (s.flags & ~flag_clr) | {cap_hit, hit_b, hit_a, ovf_set};
		n.out_a = wave_next(s.out_a, s.ctrl.act_a, is_pwm, mode == MODE_FAST_A,
			hit_a || force_a, clear_cnt && is_pwm);
		n.out_b = wave_next(s.out_b, s.ctrl.act_b, is_pwm, 1'b0,
			hit_b || force_b, clear_cnt && is_pwm);
		if (wr_ctrl)
			n.ctrl = ctrl_t'(ctrl_merged[9:0]);
		if (wr_count)
		begin
			n.count = merge16(s.count, wd, ws);
			n.block = 1'b1;
		end
		if (wr_cmpa)
			n.cmpa_buf = merge16(s.cmpa_buf, wd, ws) & cmp_mask;
		if (wr_cmpb)
			n.cmpb_buf = merge16(s.cmpb_buf, wd, ws) & cmp_mask;
		if (wr_captop)
			n.captop = merge16(s.captop, wd, ws) & cmp_mask;
		// Write channels
		if (aw_fire)
		begin
			n.aw_held = 1'b1;
			n.awaddr = axi_req.awaddr;
		end
		if (w_fire)
		begin
			n.w_held = 1'b1;
			n.wdata = axi_req.wdata;
			n.wstrb = axi_req.wstrb;
		end
		if (s.bvalid && axi_req.bready)
			n.bvalid = 1'b0;
		if (do_wr)
		begin
			n.aw_held = 1'b0;
			n.w_held = 1'b0;
			n.bvalid = 1'b1;
			n.bresp = wr_known ? RESP_OKAY : RESP_SLVERR;
		end
		// Read channel
		if (s.rvalid && axi_req.rready)
			n.rvalid = 1'b0;
		if (axi_req.arvalid && axi_rsp.arready)
		begin
			n.rvalid = 1'b1;
			n.rresp = RESP_OKAY;
			if (raddr == OFF_CTRL)
				n.rdata = {22'h000000, s.ctrl};
			else if (raddr == OFF_FORCE)
				n.rdata = 32'h00000000;
			else if (raddr == OFF_COUNT)
				n.rdata = {16'h0000, s.count};
			else if (raddr == OFF_CMPA)
				n.rdata = {16'h0000, s.cmpa_buf};
			else if (raddr == OFF_CMPB)
				n.rdata = {16'h0000, s.cmpb_buf};
			else if (raddr == OFF_CAPTOP)
				n.rdata = {16'h0000, s.captop};
			else if (raddr == OFF_FLAGS)
				n.rdata = {28'h0000000, s.flags};
			else if (raddr == OFF_STATUS)
				n.rdata = {30'h00000000, s.out_b, s.out_a};
			else
			begin
				n.rdata = 32'h00000000;
				n.rresp = RESP_SLVERR;
			end
		end
	end

	always_ff @(posedge clk)
	begin
		if (rst)
			s <= STATE_RST;
		else
			s <= n;
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign axi_rsp.awready = !s.aw_held && !s.bvalid;
	assign axi_rsp.wready = !s.w_held && !s.bvalid;
	assign axi_rsp.bvalid = s.bvalid;
	assign axi_rsp.bresp = s.bresp;
	assign axi_rsp.arready = !s.rvalid;
	assign axi_rsp.rvalid = s.rvalid;
	assign axi_rsp.rdata = s.rdata;
	assign axi_rsp.rresp = s.rresp;
	assign pin_a_out = s.out_a && s.ctrl.dir_a;
	assign pin_a_en = s.ctrl.dir_a;
	assign pin_b_out = s.out_b && s.ctrl.dir_b;
	assign pin_b_en = s.ctrl.dir_b;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	chk_none_holds_a: assert property (@(posedge clk) disable iff (rst)
		(s.ctrl.act_a == ACT_NONE) && !wr_ctrl |=> $stable(s.out_a))
	else $error("output A changed with action none");

	chk_force_sets_a: assert property (@(posedge clk) disable iff (rst)
		force_a && (s.ctrl.act_a == ACT_HIGH_MATCH) |=> s.out_a)
	else $error("force did not set output A");

	chk_normal_wrap: assert property (@(posedge clk) disable iff (rst)
		is_norm && timer_tick && (s.count == COUNT_MAX) && !wr_count
		|=> (s.count == COUNT_BOTTOM) && s.flags[FLAG_OVF])
	else $error("normal mode wrap or overflow flag wrong");

	chk_clr_clear: assert property (@(posedge clk) disable iff (rst)
		is_clr && timer_tick && !s.block && (s.count == top) && !wr_count
		|=> s.count == COUNT_BOTTOM)
	else $error("clear-on-match did not clear");

	chk_clr_no_ovf: assert property (@(posedge clk) disable iff (rst)
		is_clr && !s.flags[FLAG_OVF] && (s.count != COUNT_MAX) |=> !s.flags[FLAG_OVF])
	else $error("overflow flag set without rollover");

	chk_pwm_reload: assert property (@(posedge clk) disable iff (rst)
		is_pwm && clear_cnt |=> (s.cmpa_act == $past(s.cmpa_buf)) && s.flags[FLAG_OVF])
	else $error("compare A not reloaded at TOP");

	chk_pwm_buffered: assert property (@(posedge clk) disable iff (rst)
		is_pwm && wr_cmpa && !clear_cnt && !wr_ctrl |=> $stable(s.cmpa_act))
	else $error("buffered compare A changed early");

	chk_bottom_sets_a: assert property (@(posedge clk) disable iff (rst)
		is_pwm && (s.ctrl.act_a == ACT_LOW_MATCH) && clear_cnt && !wr_ctrl |=> s.out_a)
	else $error("output A not set at bottom");

	chk_fixed_mask: assert property (@(posedge clk) disable iff (rst)
		(mode == MODE_FAST8) && wr_cmpa |=> s.cmpa_buf[15:8] == 8'h00)
	else $error("compare A not masked to TOP");

	chk_pwm_top_clear: assert property (@(posedge clk) disable iff (rst)
		(mode == MODE_FAST9) && timer_tick && !s.block && (s.count == TOP_FIXED9) && !wr_count
		|=> s.count == COUNT_BOTTOM)
	else $error("fast PWM did not clear after TOP");

endmodule

// ==== testbench.sv ====
// Self-checking testbench of the 16-bit waveform timer
`timescale 1ns/1ps
module testbench;
	import timer16_pkg::*;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic timer_tick = 1'b0;
	axi_req_t req = '0;
	axi_rsp_t rsp;
	logic pin_a_out;
	logic pin_a_en;
	logic pin_b_out;
	logic pin_b_en;
	int errors = 0;
	int num_checks = 0;
	logic [35:0] exp_q[$];
	logic [31:0] rnd;
	logic [31:0] lvl;
	int act;

	always #4 clk = ~clk;

	timer16_waveform_modes u_dut (
		.clk(clk),
		.rst(rst),
		.timer_tick(timer_tick),
		.axi_req(req),
		.axi_rsp(rsp),
		.pin_a_out(pin_a_out),
		.pin_a_en(pin_a_en),
		.pin_b_out(pin_b_out),
		.pin_b_en(pin_b_en)
	);

	// ----------------------------------------
	// Comparison and answer monitor
	// ----------------------------------------
	task automatic check(input logic [35:0] seen, input logic [35:0] expd);
		num_checks++;
		if (seen !== expd)
		begin
			errors++;
			$display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, expd);
		end
	endtask

	// Answers are taken in order, one transfer at a time
	always @(posedge clk)
	begin
		if (rsp.rvalid && req.rready)
			check({2'h0, rsp.rresp, rsp.rdata}, exp_q.pop_front());
		if (rsp.bvalid && req.bready)
			check({2'h0, rsp.bresp, 32'h0}, exp_q.pop_front());
	end

	// ----------------------------------------
	// Bus and tick drivers
	// ----------------------------------------
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] resp);
		logic aw_ok;
		logic w_ok;
		logic b_ok;
		exp_q.push_back({2'h0, resp, 32'h0});
		aw_ok = 1'b0;
		w_ok = 1'b0;
		b_ok = 1'b0;
		@(posedge clk);
		req <= '{1'b1, a, 1'b1, d, 4'hF, 1'b1, 1'b0, 8'h00, 1'b0};
		while (!(aw_ok && w_ok))
		begin
			@(negedge clk);
			aw_ok = aw_ok || rsp.awready;
			w_ok = w_ok || rsp.wready;
			@(posedge clk);
			if (aw_ok) req.awvalid <= 1'b0;
			if (w_ok) req.wvalid <= 1'b0;
		end
		while (!b_ok)
		begin
			@(negedge clk);
			b_ok = rsp.bvalid;
			@(posedge clk);
		end
		req.bready <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] expd, input logic [1:0] resp);
		logic ok;
		exp_q.push_back({2'h0, resp, expd});
		ok = 1'b0;
		@(posedge clk);
		req.arvalid <= 1'b1;
		req.araddr <= a;
		req.rready <= 1'b1;
		while (!ok)
		begin
			@(negedge clk);
			ok = rsp.arready;
			@(posedge clk);
		end
		req.arvalid <= 1'b0;
		ok = 1'b0;
		while (!ok)
		begin
			@(negedge clk);
			ok = rsp.rvalid;
			@(posedge clk);
		end
		req.rready <= 1'b0;
	endtask

	task automatic ticks(input int n);
		@(posedge clk);
		timer_tick <= 1'b1;
		repeat (n) @(posedge clk);
		timer_tick <= 1'b0;
	endtask

	task automatic complete_run;
		$display("checks %0d mismatches %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	initial
	begin
		#200000;
		errors++;
		complete_run;
	end

	// ----------------------------------------
	// Test sequence
	// ----------------------------------------
	initial
	begin
		void'($urandom(56));
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		rd(OFF_CTRL, 32'h0, RESP_OKAY);
		rd(OFF_STATUS, 32'h0, RESP_OKAY);
		check({35'h0, pin_a_out}, 36'h0);
		rd(8'h40, 32'h0, RESP_SLVERR);
		wr(8'h40, 32'h5, RESP_SLVERR);
		wr(OFF_CMPB, 32'h7777, RESP_OKAY);
		$display("test reset done");
		wr(OFF_COUNT, 32'hFFFE, RESP_OKAY);
		ticks(2);
		rd(OFF_COUNT, 32'h0, RESP_OKAY);
		rd(OFF_FLAGS, 32'h1, RESP_OKAY);
		wr(OFF_FLAGS, 32'hF, RESP_OKAY);
		rd(OFF_FLAGS, 32'h0, RESP_OKAY);
		wr(OFF_CTRL, 32'h10, RESP_OKAY);
		wr(OFF_FORCE, 32'h1, RESP_OKAY);
		rd(OFF_STATUS, 32'h1, RESP_OKAY);
		wr(OFF_CTRL, 32'h00, RESP_OKAY);
		wr(OFF_FORCE, 32'h1, RESP_OKAY);
		rd(OFF_STATUS, 32'h1, RESP_OKAY);
		wr(OFF_CTRL, 32'h01, RESP_OKAY);
		wr(OFF_COUNT, 32'h5, RESP_OKAY);
		ticks(3);
		rd(OFF_COUNT, 32'h5, RESP_OKAY);
		$display("test normal done");
		wr(OFF_CTRL, 32'h14, RESP_OKAY);
		wr(OFF_CMPA, 32'h3, RESP_OKAY);
		wr(OFF_COUNT, 32'h0, RESP_OKAY);
		wr(OFF_FLAGS, 32'hF, RESP_OKAY);
		ticks(4);
		rd(OFF_COUNT, 32'h0, RESP_OKAY);
		rd(OFF_STATUS, 32'h0, RESP_OKAY);
		rd(OFF_FLAGS, 32'h2, RESP_OKAY);
		ticks(4);
		rd(OFF_STATUS, 32'h1, RESP_OKAY);
		check({34'h0, pin_a_en, pin_a_out}, 36'h0);
		wr(OFF_COUNT, 32'hFFF0, RESP_OKAY);
		wr(OFF_FLAGS, 32'hF, RESP_OKAY);
		ticks(16);
		rd(OFF_COUNT, 32'h0, RESP_OKAY);
		rd(OFF_FLAGS, 32'h1, RESP_OKAY);
		wr(OFF_CTRL, 32'h0C, RESP_OKAY);
		wr(OFF_CAPTOP, 32'h2, RESP_OKAY);
		wr(OFF_COUNT, 32'h0, RESP_OKAY);
		wr(OFF_FLAGS, 32'hF, RESP_OKAY);
		ticks(3);
		rd(OFF_COUNT, 32'h0, RESP_OKAY);
		rd(OFF_FLAGS, 32'h8, RESP_OKAY);
		$display("test clear on match done");
		for (act = 2; act < 4; act++)
		begin
			lvl = 32'(act == 2);
			wr(OFF_CTRL, 32'h105 | (act << 4), RESP_OKAY);
			rnd = $urandom;
			wr(OFF_CMPA, rnd, RESP_OKAY);
			rd(OFF_CMPA, rnd & 32'hFF, RESP_OKAY);
			wr(OFF_CMPA, 32'h1234, RESP_OKAY);
			wr(OFF_COUNT, 32'hFE, RESP_OKAY);
			wr(OFF_FLAGS, 32'hF, RESP_OKAY);
			ticks(2);
			rd(OFF_COUNT, 32'h0, RESP_OKAY);
			rd(OFF_STATUS, lvl, RESP_OKAY);
			rd(OFF_FLAGS, 32'h1, RESP_OKAY);
			ticks(8'h34);
			rd(OFF_STATUS, lvl, RESP_OKAY);
			ticks(1);
			rd(OFF_STATUS, lvl ^ 32'h1, RESP_OKAY);
			check({35'h0, pin_a_out}, {35'h0, ~lvl[0]});
			rd(OFF_FLAGS, 32'h3, RESP_OKAY);
			// Count 0x35 runs through TOP to bottom, restoring the level
			ticks(203);
			rd(OFF_STATUS, lvl, RESP_OKAY);
		end
		$display("test fast pwm done");
		wr(OFF_CTRL, 32'h28E, RESP_OKAY);
		wr(OFF_CAPTOP, 32'h10, RESP_OKAY);
		wr(OFF_CMPB, 32'h10, RESP_OKAY);
		wr(OFF_CMPA, 32'h20, RESP_OKAY);
		wr(OFF_COUNT, 32'h0, RESP_OKAY);
		wr(OFF_FLAGS, 32'hF, RESP_OKAY);
		ticks(17);
		rd(OFF_COUNT, 32'h0, RESP_OKAY);
		rd(OFF_FLAGS, 32'h9, RESP_OKAY);
		wr(OFF_FLAGS, 32'hF, RESP_OKAY);
		ticks(17);
		rd(OFF_FLAGS, 32'hD, RESP_OKAY);
		rd(OFF_STATUS, 32'h2, RESP_OKAY);
		check({34'h0, pin_b_en, pin_b_out}, 36'h3);
		check({34'h0, pin_a_en, pin_a_out}, 36'h0);
		wr(OFF_CTRL, 32'h11F, RESP_OKAY);
		wr(OFF_CMPA, 32'h3, RESP_OKAY);
		wr(OFF_COUNT, 32'h1F, RESP_OKAY);
		ticks(2);
		rd(OFF_STATUS, 32'h3, RESP_OKAY);
		wr(OFF_FLAGS, 32'hF, RESP_OKAY);
		ticks(4);
		rd(OFF_STATUS, 32'h2, RESP_OKAY);
		rd(OFF_FLAGS, 32'h3, RESP_OKAY);
		wr(OFF_FORCE, 32'h1, RESP_OKAY);
		rd(OFF_STATUS, 32'h2, RESP_OKAY);
		wr(OFF_CTRL, 32'h30, RESP_OKAY);
		wr(OFF_FORCE, 32'h1, RESP_OKAY);
		rd(OFF_STATUS, 32'h3, RESP_OKAY);
		check({34'h0, pin_b_en, pin_b_out}, 36'h0);
		for (act = 6; act < 8; act++)
		begin
			lvl = (act == 6) ? {16'h0000, TOP_FIXED9} : {16'h0000, TOP_FIXED10};
			wr(OFF_CTRL, 32'(act), RESP_OKAY);
			wr(OFF_CMPB, 32'hFFFF, RESP_OKAY);
			rd(OFF_CMPB, lvl, RESP_OKAY);
			wr(OFF_COUNT, lvl - 32'h1, RESP_OKAY);
			ticks(2);
			rd(OFF_COUNT, 32'h0, RESP_OKAY);
		end
		$display("test top sources done");
		complete_run;
	end
endmodule
